// file: verilog/adcsq_defines.svh
// How it works
// - scan steps the queue in order, one entry per sample, restarting per scan
// - three trigger sources; at most one selected at a time (SRC code 3 selects none)
// - trigger declared only on rising edge of selected source, or on a software trigger write when SRC selects software
// - pre-trigger: scan from start, stop at trigger, keep last M scans
// - trigger mid-scan finishes the scan, which counts among M
// - history enable set ignores triggers until M scans converted
// - early trigger stores fewer samples, always whole scans
// - middle-trigger keeps M scans before, N scans after trigger
// - scan in progress at trigger counts as first of N
// - post-trigger acquires exactly N scans from trigger then stops
// - delay-trigger counts 16-bit delay down after trigger, then N scans
// - delay clock selects timebase or sample clock
// - re-trigger repeats N scans per trigger until re-trigger count
// - triggers during a post-trigger group are ignored
// - every sample goes out straight to DMA, never held
// - descriptors hold PCI address, local address, size, next pointer
// - single transfer limited to 2M dwords; chained has no limit
// - ring of descriptors gives continuous multi-buffered transfer
// - scan interval from 24-bit timebase counter
// - sample interval from 16-bit timebase counter
// - samples per scan 9-bit, post-trigger count 24-bit
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH
`define ADCSQ_A_CTRL 8'h00
`define ADCSQ_A_SCANIV 8'h04
`define ADCSQ_A_SAMPIV 8'h08
`define ADCSQ_A_POST 8'h0C
`define ADCSQ_A_NSAMP 8'h10
`define ADCSQ_A_MCNT 8'h14
`define ADCSQ_A_DELAY 8'h18
`define ADCSQ_A_RETRIG 8'h1C
`define ADCSQ_A_STATUS 8'h20
`define ADCSQ_A_KEPT 8'h24
`define ADCSQ_A_DMALEN 8'h28
`define ADCSQ_A_QUEUE 12'h800
`define ADCSQ_MAX_SINGLE 22'h200000
`define ADCSQ_B_START 0
`define ADCSQ_B_STOP 1
`define ADCSQ_B_SWTRIG 2
`define ADCSQ_B_MEN 3
`define ADCSQ_B_RETRIG 4
`define ADCSQ_B_DLYSRC 5
`define ADCSQ_B_CHAIN 6
`define ADCSQ_F_MODE 9:8
`define ADCSQ_F_SRC 11:10
`define ADCSQ_QDEPTH 512
`endif

// file: verilog/adcsq_pkg.sv
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_PRE = 2'b00,
    ADCSQ_MID = 2'b01,
    ADCSQ_POST = 2'b10,
    ADCSQ_DLY = 2'b11
  } adcsq_mode_type;
  typedef enum logic [1:0] {
    ADCSQ_SRC_SW = 2'b00,
    ADCSQ_SRC_ANA = 2'b01,
    ADCSQ_SRC_DIG = 2'b10
  } adcsq_src_type;
  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b000,
    ADCSQ_PRESCAN = 3'b001,
    ADCSQ_FINISH = 3'b010,
    ADCSQ_WAITTRIG = 3'b011,
    ADCSQ_DELAY = 3'b100,
    ADCSQ_POSTSCAN = 3'b101
  } adcsq_state_type;
  typedef struct packed {
    logic [15:0] data;
    logic [8:0] entry;
    logic firstOfScan;
  } adcsq_sample_type;
  typedef struct packed {
    logic [31:0] pciAddr;
    logic [31:0] localAddr;
    logic [31:0] size;
    logic [31:0] nextPtr;
  } adcsq_desc_type;
endpackage : adcsq_pkg

// file: verilog/adcsq_sequencer.sv
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "adcsq_defines.svh"
module adcsq_sequencer (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic extTimebase,
  input wire logic useExtTimebase,
  input wire logic anaTrig,
  input wire logic digTrig,
  output logic convStart,
  output logic [15:0] queueEntry,
  input wire logic convDone,
  input wire logic [15:0] convData,
  output logic sampleValid,
  output adcsq_pkg::adcsq_sample_type sampleOut,
  output logic discardScans,
  output logic [15:0] discardCount,
  output logic acqBusy
);
  // ----------------------------------------------------------------
  // bus slave and configuration
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [23:0] scanIv_r;
  logic [15:0] sampleIntervalCount_r;
  logic [23:0] posttrigScanCount_r;
  logic [8:0] samplesPerScan_r;
  logic [15:0] mCount_r;
  logic [15:0] delayCount_r;
  logic [15:0] retrigNo_r;
  logic [21:0] dmaLen_r;
  logic [15:0] queue [0:`ADCSQ_QDEPTH-1];
  logic phWr_r;
  logic [11:0] phAddr_r;
  logic startPulse;
  logic stopPulse;
  logic swTrigPulse;
  adcsq_pkg::adcsq_mode_type mode;
  adcsq_pkg::adcsq_src_type src;
  adcsq_pkg::adcsq_state_type state_r;
  logic [15:0] keptScans_r;
  logic dmaErr_r;

  assign mode = adcsq_pkg::adcsq_mode_type'(ctrl_r[`ADCSQ_F_MODE]);
  assign src = adcsq_pkg::adcsq_src_type'(ctrl_r[`ADCSQ_F_SRC]);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign startPulse = phWr_r && phAddr_r == 12'(`ADCSQ_A_CTRL)
                      && hwdata[`ADCSQ_B_START];
  assign stopPulse = phWr_r && phAddr_r == 12'(`ADCSQ_A_CTRL)
                     && hwdata[`ADCSQ_B_STOP];
  assign swTrigPulse = phWr_r && phAddr_r == 12'(`ADCSQ_A_CTRL)
                       && hwdata[`ADCSQ_B_SWTRIG];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phWr_r <= 1'b0;
      phAddr_r <= 12'h000;
    end else if (hready) begin
      phWr_r <= hsel && htrans[1] && hwrite;
      phAddr_r <= haddr[11:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= 32'h0000_0000;
      scanIv_r <= 24'h000000;
      sampleIntervalCount_r <= 16'h0000;
      posttrigScanCount_r <= 24'h000000;
      samplesPerScan_r <= 9'h000;
      mCount_r <= 16'h0000;
      delayCount_r <= 16'h0000;
      retrigNo_r <= 16'h0000;
      dmaLen_r <= 22'h000000;
    end else if (phWr_r) begin
      case (phAddr_r)
        12'(`ADCSQ_A_CTRL): ctrl_r <= hwdata & 32'h0000_0FF8;
        12'(`ADCSQ_A_SCANIV): scanIv_r <= hwdata[23:0];
        12'(`ADCSQ_A_SAMPIV): sampleIntervalCount_r <= hwdata[15:0];
        12'(`ADCSQ_A_POST): posttrigScanCount_r <= hwdata[23:0];
        12'(`ADCSQ_A_NSAMP): samplesPerScan_r <= hwdata[8:0];
        12'(`ADCSQ_A_MCNT): mCount_r <= hwdata[15:0];
        12'(`ADCSQ_A_DELAY): delayCount_r <= hwdata[15:0];
        12'(`ADCSQ_A_RETRIG): retrigNo_r <= hwdata[15:0];
        12'(`ADCSQ_A_DMALEN): dmaLen_r <= hwdata[21:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (phWr_r && phAddr_r[11]) begin
      queue[phAddr_r[10:2]] <= hwdata[15:0];
    end
  end

  // single transfers over the limit are flagged; chained ones never
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dmaErr_r <= 1'b0;
    end else if (startPulse) begin
      dmaErr_r <= !hwdata[`ADCSQ_B_CHAIN]
                  && dmaLen_r > `ADCSQ_MAX_SINGLE;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        12'(`ADCSQ_A_CTRL): hrdata <= ctrl_r;
        12'(`ADCSQ_A_SCANIV): hrdata <= {8'h00, scanIv_r};
        12'(`ADCSQ_A_SAMPIV): hrdata <= {16'h0000, sampleIntervalCount_r};
        12'(`ADCSQ_A_POST): hrdata <= {8'h00, posttrigScanCount_r};
        12'(`ADCSQ_A_NSAMP): hrdata <= {23'h000000, samplesPerScan_r};
        12'(`ADCSQ_A_MCNT): hrdata <= {16'h0000, mCount_r};
        12'(`ADCSQ_A_DELAY): hrdata <= {16'h0000, delayCount_r};
        12'(`ADCSQ_A_RETRIG): hrdata <= {16'h0000, retrigNo_r};
        12'(`ADCSQ_A_STATUS): hrdata <= {27'h0000000, dmaErr_r, acqBusy,
                                         state_r};
        12'(`ADCSQ_A_KEPT): hrdata <= {16'h0000, keptScans_r};
        12'(`ADCSQ_A_DMALEN): hrdata <= {10'h000, dmaLen_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timebase and trigger detection
  // ----------------------------------------------------------------
  logic extTb_r;
  logic tbTick;
  logic digPrev_r;
  logic anaPrev_r;
  logic trigEvent;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      extTb_r <= 1'b0;
      digPrev_r <= 1'b0;
      anaPrev_r <= 1'b0;
    end else begin
      extTb_r <= extTimebase;
      digPrev_r <= digTrig;
      anaPrev_r <= anaTrig;
    end
  end

  // internal timebase taken as the system clock itself
  assign tbTick = useExtTimebase ? (extTimebase && !extTb_r) : 1'b1;

  always_comb begin
    case (src)
      adcsq_pkg::ADCSQ_SRC_SW: trigEvent = swTrigPulse;
      adcsq_pkg::ADCSQ_SRC_ANA: trigEvent = anaTrig && !anaPrev_r;
      adcsq_pkg::ADCSQ_SRC_DIG: trigEvent = digTrig && !digPrev_r;
      default: trigEvent = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // scan and sample timing
  // ----------------------------------------------------------------
  logic [23:0] scanCnt_r;
  logic [15:0] sampCnt_r;
  logic [8:0] entry_r;
  logic scanning;
  logic inScan_r;
  logic scanTick;
  logic sampTick;
  logic scanEnd;

  assign scanning = state_r == adcsq_pkg::ADCSQ_PRESCAN
                    || state_r == adcsq_pkg::ADCSQ_FINISH
                    || state_r == adcsq_pkg::ADCSQ_POSTSCAN;
  assign scanTick = scanning && tbTick && scanCnt_r == 24'h000000;
  assign sampTick = inScan_r && tbTick && sampCnt_r == 16'h0000;
  assign scanEnd = sampTick && entry_r == samplesPerScan_r - 9'h001;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scanCnt_r <= 24'h000000;
    end else if (startPulse || !scanning) begin
      scanCnt_r <= 24'h000000;
    end else if (tbTick) begin
      scanCnt_r <= scanCnt_r == 24'h000000 ? scanIv_r - 24'h000001
                                            : scanCnt_r - 24'h000001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sampCnt_r <= 16'h0000;
      entry_r <= 9'h000;
      inScan_r <= 1'b0;
    end else if (startPulse || !scanning) begin
      sampCnt_r <= 16'h0000;
      if (!startPulse && state_r == adcsq_pkg::ADCSQ_DELAY) begin
        sampCnt_r <= !tbTick ? sampCnt_r
          : sampCnt_r != 16'h0000 ? sampCnt_r - 16'h0001
          : sampleIntervalCount_r - 16'h0001;
      end
      entry_r <= 9'h000;
      inScan_r <= 1'b0;
    end else if (scanTick && !inScan_r) begin
      inScan_r <= 1'b1;
      entry_r <= 9'h000;
      sampCnt_r <= 16'h0000;
    end else if (tbTick && inScan_r) begin
      if (sampCnt_r == 16'h0000) begin
        sampCnt_r <= sampleIntervalCount_r - 16'h0001;
        entry_r <= entry_r + 9'h001;
        inScan_r <= !scanEnd;
      end else begin
        sampCnt_r <= sampCnt_r - 16'h0001;
      end
    end
  end

  assign convStart = sampTick;
  assign queueEntry = queue[entry_r];

  // every conversion goes straight out; the DMA side never waits
  logic [8:0] doneEntry_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      doneEntry_r <= 9'h000;
    end else if (sampTick) begin
      doneEntry_r <= entry_r;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sampleValid <= 1'b0;
      sampleOut <= '0;
    end else begin
      sampleValid <= convDone;
      if (convDone) begin
        sampleOut <= {convData, doneEntry_r, doneEntry_r == 9'h000};
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger-mode sequencer
  // ----------------------------------------------------------------
  logic [15:0] preScans_r;
  logic [23:0] postLeft_r;
  logic [15:0] dlyCnt_r;
  logic [15:0] retrigLeft_r;
  logic dlyTick;
  logic histOk;
  logic lastGroup;

  assign dlyTick = ctrl_r[`ADCSQ_B_DLYSRC] ? sampCnt_r == 16'h0000 && tbTick
                                            : tbTick;
  assign histOk = !ctrl_r[`ADCSQ_B_MEN] || preScans_r >= mCount_r;
  assign lastGroup = !ctrl_r[`ADCSQ_B_RETRIG]
                     || retrigLeft_r <= 16'h0001;
  assign acqBusy = state_r != adcsq_pkg::ADCSQ_IDLE;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= adcsq_pkg::ADCSQ_IDLE;
      preScans_r <= 16'h0000;
      postLeft_r <= 24'h000000;
      dlyCnt_r <= 16'h0000;
      retrigLeft_r <= 16'h0000;
    end else if (stopPulse) begin
      state_r <= adcsq_pkg::ADCSQ_IDLE;
    end else if (startPulse) begin
      preScans_r <= 16'h0000;
      postLeft_r <= posttrigScanCount_r;
      dlyCnt_r <= delayCount_r;
      retrigLeft_r <= retrigNo_r;
      if (hwdata[`ADCSQ_F_MODE] == adcsq_pkg::ADCSQ_PRE
          || hwdata[`ADCSQ_F_MODE] == adcsq_pkg::ADCSQ_MID) begin
        state_r <= adcsq_pkg::ADCSQ_PRESCAN;
      end else begin
        state_r <= adcsq_pkg::ADCSQ_WAITTRIG;
      end
    end else begin
      case (state_r)
        adcsq_pkg::ADCSQ_PRESCAN: begin
          if (scanEnd && preScans_r != 16'hFFFF) begin
            preScans_r <= preScans_r + 16'h0001;
          end
          if (trigEvent && histOk) begin
            if (mode == adcsq_pkg::ADCSQ_MID) begin
              state_r <= adcsq_pkg::ADCSQ_POSTSCAN;
            end else if (inScan_r && !scanEnd) begin
              state_r <= adcsq_pkg::ADCSQ_FINISH;
            end else begin
              state_r <= adcsq_pkg::ADCSQ_IDLE;
            end
          end
        end
        adcsq_pkg::ADCSQ_FINISH: begin
          if (scanEnd) begin
            preScans_r <= preScans_r + 16'h0001;
            state_r <= adcsq_pkg::ADCSQ_IDLE;
          end
        end
        adcsq_pkg::ADCSQ_WAITTRIG: begin
          if (trigEvent) begin
            postLeft_r <= posttrigScanCount_r;
            dlyCnt_r <= delayCount_r;
            state_r <= mode == adcsq_pkg::ADCSQ_DLY
                       ? adcsq_pkg::ADCSQ_DELAY
                       : adcsq_pkg::ADCSQ_POSTSCAN;
          end
        end
        adcsq_pkg::ADCSQ_DELAY: begin
          if (dlyCnt_r == 16'h0000) begin
            state_r <= adcsq_pkg::ADCSQ_POSTSCAN;
          end else if (dlyTick) begin
            dlyCnt_r <= dlyCnt_r - 16'h0001;
          end
        end
        adcsq_pkg::ADCSQ_POSTSCAN: begin
          // triggers are not looked at here
          if (scanEnd) begin
            postLeft_r <= postLeft_r - 24'h000001;
            if (postLeft_r <= 24'h000001) begin
              if (lastGroup) begin
                state_r <= adcsq_pkg::ADCSQ_IDLE;
              end else begin
                retrigLeft_r <= retrigLeft_r - 16'h0001;
                state_r <= adcsq_pkg::ADCSQ_WAITTRIG;
              end
            end
          end
        end
        default: state_r <= adcsq_pkg::ADCSQ_IDLE;
      endcase
    end
  end

  // scans kept before the trigger, capped at M
  assign keptScans_r = preScans_r < mCount_r ? preScans_r : mCount_r;

  // the DMA sink drops the oldest extra whole scans after the run
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      discardScans <= 1'b0;
      discardCount <= 16'h0000;
    end else begin
      discardScans <= state_r == adcsq_pkg::ADCSQ_IDLE
                      && (mode == adcsq_pkg::ADCSQ_PRE
                          || mode == adcsq_pkg::ADCSQ_MID)
                      && preScans_r > mCount_r;
      discardCount <= preScans_r > mCount_r ? preScans_r - mCount_r
                                            : 16'h0000;
    end
  end
endmodule : adcsq_sequencer

// file: tb/adcsq_props.sv
`timescale 1ns/10ps
module adcsq_props_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic convStart,
  input wire logic convDone,
  input wire logic [15:0] convData,
  input wire logic sampleValid,
  input wire adcsq_pkg::adcsq_sample_type sampleOut,
  input wire logic acqBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // helper: entry of the previous sample
  // ----------------------------------------
  logic [8:0] lastEntry_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lastEntry_r <= 9'h000;
    end else if (sampleValid) begin
      lastEntry_r <= sampleOut.entry;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sample_latency_a: assert property (
    convDone |=> sampleValid && sampleOut.data == $past(convData))
    else $error("converter result not passed on next cycle");
  sample_cause_a: assert property (
    sampleValid |-> $past(convDone))
    else $error("sample emitted without a conversion");
  scan_first_a: assert property (
    sampleValid && sampleOut.firstOfScan |-> sampleOut.entry == 9'h000)
    else $error("scan does not begin at queue entry zero");
  queue_order_a: assert property (
    sampleValid && !sampleOut.firstOfScan
      |-> sampleOut.entry == lastEntry_r + 9'h001)
    else $error("queue entries out of order");
  idle_quiet_a: assert property (
    !acqBusy |-> !convStart)
    else $error("conversion started while idle");
  bus_ready_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  bus_okay_a: assert property (!hresp)
    else $error("slave gave a non okay response");
  unmapped_read_a: assert property (
    hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h0FC
      |=> hrdata == 32'h00000000)
    else $error("unmapped read returned nonzero");
endmodule : adcsq_props_chk

// file: tb/adcsq_conv_model.sv
`timescale 1ns/10ps
// converter stand-in: answers each start after a settable latency and
// returns the queue word, so data order exposes the queue order
module adcsq_conv_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic convStart,
  input wire logic [15:0] queueEntry,
  input wire logic [3:0] lat,
  output logic convDone,
  output logic [15:0] convData
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [15:0] word_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      word_r <= 16'h0000;
      convDone <= 1'b0;
      convData <= 16'h0000;
    end else begin
      convDone <= 1'b0;
      // data bus churns outside the strobe, never holds the last value
      convData <= ~convData;
      if (convStart) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        word_r <= queueEntry;
      end else if (busy_r) begin
        if (cnt_r == 4'h0) begin
          busy_r <= 1'b0;
          convDone <= 1'b1;
          convData <= word_r;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule : adcsq_conv_model

// file: tb/adc_scan_trigger_sequencer_test.sv
`timescale 1ns/10ps
`include "adcsq_defines.svh"
module adc_scan_trigger_sequencer_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic anaTrig = 1'b0;
  logic digTrig = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [31:0] hrdata, rdv, ctrlV;
  logic hreadyout, hresp, convStart, convDone, sampleValid;
  logic discardScans, acqBusy;
  logic [15:0] queueEntry, convData, discardCount;
  logic [15:0] qword[3];
  adcsq_pkg::adcsq_sample_type sampleOut;
  adcsq_pkg::adcsq_sample_type expq[$];
  int failures = 0;
  int samples_checked = 0;
  always #5 clock = ~clock;
  adcsq_sequencer dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .extTimebase(1'b0),
    .useExtTimebase(1'b0), .anaTrig(anaTrig), .digTrig(digTrig),
    .convStart(convStart), .queueEntry(queueEntry), .convDone(convDone),
    .convData(convData), .sampleValid(sampleValid), .sampleOut(sampleOut),
    .discardScans(discardScans), .discardCount(discardCount),
    .acqBusy(acqBusy));
  adcsq_conv_model conv (.clock(clock), .sys_rst(sys_rst),
    .convStart(convStart), .queueEntry(queueEntry), .lat(lat),
    .convDone(convDone), .convData(convData));
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic fail(input string m);
    failures++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail
  task automatic print_verdict;
    $display("failures %0d samples %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic busWait;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail("bus hang");
        print_verdict;
      end
      @(posedge clock);
    end
  endtask : busWait
  // hsel stays up; an idle htrans marks the gaps between transfers
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    busWait;
    htrans <= 2'b00;
    hwdata <= d;
    busWait;
    rdv = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    samples_checked++;
    if (rdv !== e) fail("register read mismatch");
  endtask : rdChk
  // ----------------------------------------
  // acquisition helpers
  // ----------------------------------------
  function automatic logic [31:0] cfg(input logic [1:0] mode,
      input logic [1:0] src, input logic [3:0] flags);
    return {20'h00000, src, mode, 1'b0, flags, 3'h0};
  endfunction : cfg
  task automatic run(input logic [31:0] c, input logic [31:0] post,
                     input logic [31:0] m);
    wr(`ADCSQ_A_SCANIV, 32'h00000050);
    wr(`ADCSQ_A_SAMPIV, 32'h00000014);
    wr(`ADCSQ_A_NSAMP, 32'h00000003);
    wr(`ADCSQ_A_POST, post);
    wr(`ADCSQ_A_MCNT, m);
    for (int e = 0; e < 3; e++) wr(`ADCSQ_A_QUEUE + 4 * e, {16'h0, qword[e]});
    ctrlV = c;
    wr(`ADCSQ_A_CTRL, c | 32'h00000001);
  endtask : run
  task automatic fire(input int src);
    case (src)
      0: wr(`ADCSQ_A_CTRL, ctrlV | 32'h00000004);
      1: begin
        anaTrig <= 1'b1;
        cyc(3);
        anaTrig <= 1'b0;
      end
      default: begin
        digTrig <= 1'b1;
        cyc(3);
        digTrig <= 1'b0;
      end
    endcase
    cyc(1);
  endtask : fire
  task automatic expectScans(input int n);
    for (int s = 0; s < n; s++) begin
      for (int e = 0; e < 3; e++) begin
        expq.push_back(adcsq_pkg::adcsq_sample_type'{qword[e], 9'(e), e == 0});
      end
    end
  endtask : expectScans
  task automatic waitLeft(input int k);
    int n;
    n = 0;
    while (expq.size() > k) begin
      cyc(1);
      n++;
      if (n > 3000) begin
        fail("samples never came");
        print_verdict;
      end
    end
  endtask : waitLeft
  task automatic idle;
    waitLeft(0);
    for (int n = 0; acqBusy !== 1'b0; n++) begin
      cyc(1);
      if (n > 3000) begin
        fail("acquisition never ended");
        print_verdict;
      end
    end
    cyc(60);
  endtask : idle
  // ----------------------------------------
  // sample monitor: every sample leaves at once
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst === 1'b0 && sampleValid === 1'b1) begin
      if (expq.size() == 0) begin
        fail("unexpected sample");
      end else begin
        samples_checked++;
        if (sampleOut !== expq.pop_front()) fail("sample mismatch");
      end
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hCF29));
    for (int e = 0; e < 3; e++) qword[e] = 16'($urandom);
    cyc(20);
    sys_rst <= 1'b0;
    cyc(1);
    rdChk(`ADCSQ_A_STATUS, 32'h00000000);
    rdChk(32'h000000FC, 32'h00000000);
    for (int s = 0; s < 3; s++) begin
      lat <= 4'($urandom_range(6));
      run(cfg(adcsq_pkg::ADCSQ_POST, 2'(s), 4'h0), 32'h2, 32'h0);
      fire((s + 1) % 3);
      cyc(40);
      xfer(1'b0, `ADCSQ_A_STATUS, 32'h00000000);
      samples_checked++;
      if (rdv[3] !== 1'b1) fail("status not busy");
      expectScans(2);
      fire(s);
      idle;
    end
    wr(`ADCSQ_A_DELAY, 32'h00000005);
    for (int d = 0; d < 2; d++) begin
      run(cfg(adcsq_pkg::ADCSQ_DLY, 2'h0, d ? 4'h4 : 4'h0), 32'h1, 32'h0);
      fire(0);
      cyc(d ? 80 : 5);
      expectScans(1);
      idle;
    end
    wr(`ADCSQ_A_RETRIG, 32'h00000002);
    run(cfg(adcsq_pkg::ADCSQ_POST, 2'h0, 4'h2), 32'h1, 32'h0);
    fire(0);
    fire(0);
    expectScans(1);
    waitLeft(0);
    cyc(150);
    expectScans(1);
    fire(0);
    idle;
    expectScans(4);
    run(cfg(adcsq_pkg::ADCSQ_PRE, 2'h0, 4'h1), 32'h0, 32'h2);
    waitLeft(11);
    fire(0);
    waitLeft(2);
    fire(0);
    idle;
    samples_checked++;
    if (discardScans !== 1'b1 || discardCount !== 16'h0002) begin
      fail("pre-trigger history trim wrong");
    end
    rdChk(`ADCSQ_A_KEPT, 32'h00000002);
    expectScans(2);
    run(cfg(adcsq_pkg::ADCSQ_MID, 2'h0, 4'h0), 32'h2, 32'h2);
    waitLeft(5);
    fire(0);
    idle;
    samples_checked++;
    if (discardCount !== 16'h0000) fail("middle trim wrong");
    print_verdict;
  end
endmodule : adc_scan_trigger_sequencer_test
bind adcsq_sequencer adcsq_props_chk chk (.clock(clock), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .convStart(convStart), .convDone(convDone), .convData(convData),
  .sampleValid(sampleValid), .sampleOut(sampleOut), .acqBusy(acqBusy));
